// >>> acs_pkg.sv
// package: register map, field layout and routing codes for the input select block
package acs_pkg;
    // register byte offsets on the axi4-lite bus
    localparam logic [3:0] MULTI_SEL_OFF   = 4'h0;
    localparam logic [3:0] FIRST_SEL_OFF   = 4'h4;
    localparam logic [3:0] SCAN_MASK_OFF   = 4'h8;
    localparam logic [3:0] PIN_CFG_OFF     = 4'hc;
    // writable bits per register
    localparam logic [15:0] MULTI_SEL_MASK = 16'h0707;
    localparam logic [15:0] FIRST_SEL_MASK = 16'h9f9f;
    localparam logic [15:0] TEN_BIT_MASK   = 16'h03ff;
    localparam logic [15:0] REG_RESET      = 16'h0000;
    // field positions
    localparam int MC_POS_A = 0;
    localparam int MC_NEG_A = 1;
    localparam int MC_POS_B = 8;
    localparam int MC_NEG_B = 9;
    localparam int FC_POS_A = 0;
    localparam int FC_NEG_A = 7;
    localparam int FC_POS_B = 8;
    localparam int FC_NEG_B = 15;
    // routing code on the mux outputs
    localparam logic [3:0] RT_NONE = 4'hf; // not connected / reserved
    localparam logic [3:0] RT_VREF = 4'he; // negative or low reference
    localparam logic [1:0] AXI_OKAY   = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;
    localparam logic [1:0] AXI_DECERR = 2'b11;
endpackage

// >>> acs_input_select.sv
// input channel select registers and analog mux routing decode
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - twelve-bit mode makes all channel 1-3 codes reserved, no routing.
// - ten-bit negative codes 00 and 01 route negative reference to channels 1-3.
// - negative code 10 gives inputs 6,7 and 8 (large) or 6,7 and none (small).
// - negative code 11 gives input 9 to channel 1 on large; reserved small.
// - positive 1 gives input 3; channels 2,3 get 4,5 on large only.
// - positive 0 gives inputs 0,1,2 to channels 1,2,3 on both variants.
// - multi-channel register holds sample B at bits 10-8, sample A at 2-0.
// - small variant: codes 4,5 reserved, 6,7 select inputs 6,7.
// - scan mask bit x includes analog input x in the scan.
// - all scan bits writable; absent input in scan converts low reference.
// - pin config 1 is digital with port read, mux at ground; 0 analog.
// - all ten pin config bits read/write; absent inputs have no effect.
// - module disable overrides config and puts all shared pins digital.
// - unimplemented bits read as zero.
module acs_input_select
    import acs_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RST_B,
    input  wire logic [3:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [3:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    input  wire logic        TWELVE_BIT_MODE_SELECT,
    input  wire logic        SAMPLE_SET_B,
    input  wire logic        CONVERTER_MODULE_DISABLE,
    input  wire logic        SCAN_ACTIVE,
    input  wire logic [3:0]  SCAN_INPUT,
    output logic [3:0]       CH0_POS_ROUTE,
    output logic [3:0]       CH0_NEG_ROUTE,
    output logic [3:0]       CH1_POS_ROUTE,
    output logic [3:0]       CH2_POS_ROUTE,
    output logic [3:0]       CH3_POS_ROUTE,
    output logic [3:0]       CH1_NEG_ROUTE,
    output logic [3:0]       CH2_NEG_ROUTE,
    output logic [3:0]       CH3_NEG_ROUTE,
    output logic [9:0]       SCAN_INCLUDE,
    output logic [9:0]       PIN_DIGITAL,
    output logic [9:0]       PORT_READ_EN,
    output logic [9:0]       MUX_TO_GROUND
);
    // ************************************************************
    // reset release
    // ************************************************************
    // chk_en_q lags rst_n one edge: checks skip the flops' last reset edge
    logic rst_s1_q, rst_n, chk_en_q;
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
            chk_en_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
            chk_en_q <= rst_n;
        end
    end

    // ************************************************************
    // bus slave
    // ************************************************************
    typedef enum logic [2:0] {
        WR_IDLE = 3'b001,
        WR_RESP = 3'b010,
        WR_HOLD = 3'b100
    } acs_wr_e;
    acs_wr_e     wst_q, wst_d;
    logic        aw_got_q, aw_got_d, w_got_q, w_got_d;
    logic [3:0]  awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0]  wstrb_q, wstrb_d;
    logic [1:0]  bresp_q, bresp_d;
    logic [15:0] msel_q, msel_d, fsel_q, fsel_d, scan_q, scan_d, pin_analog_digital_cfg_q, pin_analog_digital_cfg_d;
    logic        rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0]  rresp_q, rresp_d;
    assign S_AXI_AWREADY = (wst_q == WR_IDLE) && !aw_got_q;
    assign S_AXI_WREADY  = (wst_q == WR_IDLE) && !w_got_q;
    assign S_AXI_BVALID  = (wst_q == WR_RESP);
    assign S_AXI_BRESP   = bresp_q;
    assign S_AXI_ARREADY = !rvalid_q;
    assign S_AXI_RVALID  = rvalid_q;
    assign S_AXI_RDATA   = rdata_q;
    assign S_AXI_RRESP   = rresp_q;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s, input logic [15:0] m);
        logic [15:0] v;
        v[7:0]  = s[0] ? d[7:0]  : old[7:0];
        v[15:8] = s[1] ? d[15:8] : old[15:8];
        return v & m;
    endfunction

    always_comb begin
        wst_d    = wst_q;
        aw_got_d = aw_got_q;
        w_got_d  = w_got_q;
        awaddr_d = awaddr_q;
        wdata_d  = wdata_q;
        wstrb_d  = wstrb_q;
        bresp_d  = bresp_q;
        msel_d   = msel_q;
        fsel_d   = fsel_q;
        scan_d   = scan_q;
        pin_analog_digital_cfg_d   = pin_analog_digital_cfg_q;
        case (wst_q)
            WR_IDLE: begin
                if (S_AXI_AWVALID && !aw_got_q) begin
                    aw_got_d = 1'b1;
                    awaddr_d = S_AXI_AWADDR;
                end
                if (S_AXI_WVALID && !w_got_q) begin
                    w_got_d = 1'b1;
                    wdata_d = S_AXI_WDATA;
                    wstrb_d = S_AXI_WSTRB;
                end
                if (aw_got_q && w_got_q) begin
                    wst_d = WR_HOLD;
                end
            end
            WR_HOLD: begin
                bresp_d  = AXI_OKAY;
                case ({awaddr_q[3:2], 2'b00})
                    MULTI_SEL_OFF: msel_d = merge16(msel_q, wdata_q, wstrb_q, MULTI_SEL_MASK);
                    FIRST_SEL_OFF: fsel_d = merge16(fsel_q, wdata_q, wstrb_q, FIRST_SEL_MASK);
                    SCAN_MASK_OFF: scan_d = merge16(scan_q, wdata_q, wstrb_q, TEN_BIT_MASK);
                    PIN_CFG_OFF:   pin_analog_digital_cfg_d = merge16(pin_analog_digital_cfg_q, wdata_q, wstrb_q, TEN_BIT_MASK);
                    default:       bresp_d = AXI_DECERR;
                endcase
                aw_got_d = 1'b0;
                w_got_d  = 1'b0;
                wst_d    = WR_RESP;
            end
            WR_RESP: begin
                if (S_AXI_BREADY) begin
                    wst_d = WR_IDLE;
                end
            end
            default: wst_d = WR_IDLE;
        endcase
    end

    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (rvalid_q && S_AXI_RREADY) begin
            rvalid_d = 1'b0;
        end
        if (!rvalid_q && S_AXI_ARVALID) begin
            rvalid_d = 1'b1;
            rresp_d  = AXI_OKAY;
            rdata_d  = 32'h0000_0000;
            case ({S_AXI_ARADDR[3:2], 2'b00})
                MULTI_SEL_OFF: rdata_d = {16'h0000, msel_q};
                FIRST_SEL_OFF: rdata_d = {16'h0000, fsel_q};
                SCAN_MASK_OFF: rdata_d = {16'h0000, scan_q};
                PIN_CFG_OFF:   rdata_d = {16'h0000, pin_analog_digital_cfg_q};
                default:       rresp_d = AXI_DECERR;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            wst_q    <= WR_IDLE;
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
            bresp_q  <= AXI_OKAY;
            msel_q   <= REG_RESET;
            fsel_q   <= REG_RESET;
            scan_q   <= REG_RESET;
            pin_analog_digital_cfg_q   <= REG_RESET;
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= AXI_OKAY;
        end else begin
            wst_q    <= wst_d;
            aw_got_q <= aw_got_d;
            w_got_q  <= w_got_d;
            awaddr_q <= awaddr_d;
            wdata_q  <= wdata_d;
            wstrb_q  <= wstrb_d;
            bresp_q  <= bresp_d;
            msel_q   <= msel_d;
            fsel_q   <= fsel_d;
            scan_q   <= scan_d;
            pin_analog_digital_cfg_q   <= pin_analog_digital_cfg_d;
            rvalid_q <= rvalid_d;
            rdata_q  <= rdata_d;
            rresp_q  <= rresp_d;
        end
    end

    // ************************************************************
    // routing decode
    // ************************************************************
    logic       mc_pos, fc_neg, in_exists;
    logic [1:0] mc_neg;
    logic [4:0] fc_pos;
    logic [3:0] r0p_d, r0n_d, r1p_d, r2p_d, r3p_d, r1n_d, r2n_d, r3n_d;
    logic [3:0] r0p_q, r0n_q, r1p_q, r2p_q, r3p_q, r1n_q, r2n_q, r3n_q;
    logic [9:0] present;
    logic [9:0] dig_d, dig_q;

    // absent inputs on the small variant are 4, 5, 8 and 9
    assign present = LARGE_VARIANT ? 10'h3ff : 10'h0cf;

    always_comb begin
        mc_pos = SAMPLE_SET_B ? msel_q[MC_POS_B] : msel_q[MC_POS_A];
        mc_neg = SAMPLE_SET_B ? msel_q[MC_NEG_B +: 2] : msel_q[MC_NEG_A +: 2];
        fc_neg = SAMPLE_SET_B ? fsel_q[FC_NEG_B] : fsel_q[FC_NEG_A];
        fc_pos = SAMPLE_SET_B ? fsel_q[FC_POS_B +: 5] : fsel_q[FC_POS_A +: 5];
        r0n_d  = fc_neg ? 4'h1 : RT_VREF;
        // channel 0 positive, scan overrides; absent input converts low reference in scan, RT_NONE otherwise
        if (SCAN_ACTIVE) begin
            in_exists = (SCAN_INPUT < 4'ha) && present[SCAN_INPUT];
            r0p_d     = in_exists ? SCAN_INPUT : RT_VREF;
        end else begin
            in_exists = (fc_pos < 5'd10) && present[fc_pos[3:0]];
            r0p_d     = in_exists ? fc_pos[3:0] : RT_NONE;
        end
        r1p_d = RT_NONE;
        r2p_d = RT_NONE;
        r3p_d = RT_NONE;
        r1n_d = RT_NONE;
        r2n_d = RT_NONE;
        r3n_d = RT_NONE;
        if (!TWELVE_BIT_MODE_SELECT) begin
            if (!mc_pos) begin
                r1p_d = 4'h0;
                r2p_d = 4'h1;
                r3p_d = 4'h2;
            end else begin
                r1p_d = 4'h3;
                r2p_d = LARGE_VARIANT ? 4'h4 : RT_NONE;
                r3p_d = LARGE_VARIANT ? 4'h5 : RT_NONE;
            end
            case (mc_neg)
                2'b00, 2'b01: begin
                    r1n_d = RT_VREF;
                    r2n_d = RT_VREF;
                    r3n_d = RT_VREF;
                end
                2'b10: begin
                    r1n_d = 4'h6;
                    r2n_d = 4'h7;
                    r3n_d = LARGE_VARIANT ? 4'h8 : RT_NONE;
                end
                2'b11: r1n_d = LARGE_VARIANT ? 4'h9 : RT_NONE;
                default: r1n_d = RT_NONE;
            endcase
        end
        // module disable forces every shared pin digital
        dig_d = CONVERTER_MODULE_DISABLE ? present : (pin_analog_digital_cfg_q[9:0] & present);
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            {r0p_q, r0n_q, r1p_q, r2p_q} <= {4{RT_NONE}};
            {r3p_q, r1n_q, r2n_q, r3n_q} <= {4{RT_NONE}};
            dig_q <= 10'h000;
        end else begin
            {r0p_q, r0n_q, r1p_q, r2p_q} <= {r0p_d, r0n_d, r1p_d, r2p_d};
            {r3p_q, r1n_q, r2n_q, r3n_q} <= {r3p_d, r1n_d, r2n_d, r3n_d};
            dig_q <= dig_d;
        end
    end

    assign CH0_POS_ROUTE = r0p_q;
    assign CH0_NEG_ROUTE = r0n_q;
    assign CH1_POS_ROUTE = r1p_q;
    assign CH2_POS_ROUTE = r2p_q;
    assign CH3_POS_ROUTE = r3p_q;
    assign CH1_NEG_ROUTE = r1n_q;
    assign CH2_NEG_ROUTE = r2n_q;
    assign CH3_NEG_ROUTE = r3n_q;
    assign SCAN_INCLUDE  = scan_q[9:0];
    assign PIN_DIGITAL   = dig_q;
    assign PORT_READ_EN  = dig_q;
    assign MUX_TO_GROUND = dig_q;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!chk_en_q);

    a_twelve_reserved: assert property (TWELVE_BIT_MODE_SELECT |=>
        {r1p_q, r2p_q, r3p_q, r1n_q, r2n_q, r3n_q} == {6{RT_NONE}})
        else $error("channel 1-3 routed in twelve-bit mode");
    a_neg_ref: assert property (!TWELVE_BIT_MODE_SELECT && !mc_neg[1] |=> r2n_q == RT_VREF)
        else $error("negative reference not routed");
    a_neg_ten: assert property (!TWELVE_BIT_MODE_SELECT && mc_neg == 2'b10 |=> r1n_q == 4'h6)
        else $error("code 10 routing wrong");
    a_neg_elev: assert property (!TWELVE_BIT_MODE_SELECT && mc_neg == 2'b11 |=>
        r2n_q == RT_NONE)
        else $error("code 11 channel 2 connected");
    a_pos_one: assert property (!TWELVE_BIT_MODE_SELECT && mc_pos |=> r1p_q == 4'h3)
        else $error("positive 1 routing wrong");
    a_pos_zero: assert property (!TWELVE_BIT_MODE_SELECT && !mc_pos |=> r3p_q == 4'h2)
        else $error("positive 0 routing wrong");
    a_ch0_neg: assert property (fc_neg |=> r0n_q == 4'h1)
        else $error("channel 0 negative wrong");
    a_disable_dig: assert property (CONVERTER_MODULE_DISABLE |=> PIN_DIGITAL == present)
        else $error("disable did not force digital");
    a_read_zero: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0000)
        else $error("upper read bits nonzero");
    a_write_resp: assert property (wst_q == WR_HOLD |=> S_AXI_BVALID)
        else $error("write not answered");
    c_write: cover property (wst_q == WR_RESP && S_AXI_BREADY);
    c_read: cover property (S_AXI_RVALID && S_AXI_RREADY);
    c_set_b: cover property (SAMPLE_SET_B && mc_neg == 2'b10);
    c_scan_absent: cover property (SCAN_ACTIVE && r0p_d == RT_VREF);
endmodule

// >>> adc_input_channel_select_bench.sv
// self-checking bench for the input select block
`timescale 1ns/1ps
module adc_input_channel_select_bench;
    import acs_pkg::*;
    logic        clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
    logic        tw, sel_b, dis, scan_act, awready, wready, bvalid, arready, rvalid;
    logic [3:0]  awaddr, araddr, scan_in, r0p, r0n, r1p, r2p, r3p, r1n, r2n, r3n;
    logic [31:0] wdata, rdata, rd_q;
    logic [1:0]  bresp, rresp;
    logic [9:0]  scan_inc, pin_dig, prd_en, mux_gnd;
    logic [3:0]  s_r0p, s_r0n, s_r1p, s_r2p, s_r3p, s_r1n, s_r2n, s_r3n;
    logic [9:0]  s_pin_dig;
    int          n_errors, checks_done, cycles;

    acs_input_select #(.LARGE_VARIANT(1'b1)) uut (
        .SYS_CLK(clk), .RST_B(rst_b), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .TWELVE_BIT_MODE_SELECT(tw), .SAMPLE_SET_B(sel_b), .CONVERTER_MODULE_DISABLE(dis),
        .SCAN_ACTIVE(scan_act), .SCAN_INPUT(scan_in), .CH0_POS_ROUTE(r0p),
        .CH0_NEG_ROUTE(r0n), .CH1_POS_ROUTE(r1p), .CH2_POS_ROUTE(r2p), .CH3_POS_ROUTE(r3p),
        .CH1_NEG_ROUTE(r1n), .CH2_NEG_ROUTE(r2n), .CH3_NEG_ROUTE(r3n),
        .SCAN_INCLUDE(scan_inc), .PIN_DIGITAL(pin_dig), .PORT_READ_EN(prd_en),
        .MUX_TO_GROUND(mux_gnd)
    );

    // small variant shares every input; its bus answers match the large one
    acs_input_select #(.LARGE_VARIANT(1'b0)) uut_small (
        .SYS_CLK(clk), .RST_B(rst_b), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(), .S_AXI_BRESP(),
        .S_AXI_BVALID(), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(), .S_AXI_RDATA(),
        .S_AXI_RRESP(), .S_AXI_RVALID(), .S_AXI_RREADY(rready),
        .TWELVE_BIT_MODE_SELECT(tw), .SAMPLE_SET_B(sel_b), .CONVERTER_MODULE_DISABLE(dis),
        .SCAN_ACTIVE(scan_act), .SCAN_INPUT(scan_in), .CH0_POS_ROUTE(s_r0p),
        .CH0_NEG_ROUTE(s_r0n), .CH1_POS_ROUTE(s_r1p), .CH2_POS_ROUTE(s_r2p),
        .CH3_POS_ROUTE(s_r3p), .CH1_NEG_ROUTE(s_r1n), .CH2_NEG_ROUTE(s_r2n),
        .CH3_NEG_ROUTE(s_r3n), .SCAN_INCLUDE(), .PIN_DIGITAL(s_pin_dig), .PORT_READ_EN(),
        .MUX_TO_GROUND()
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ********************************
    // helpers
    // ********************************
    task automatic summarize();
        $display("errors=%0d checks=%0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // answer latency is the slave's; wait for it, the timeout guards a hang
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bit done;
        done = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                done = 1;
                bready <= 1'b0;
                chk({30'h0, bresp}, {30'h0, AXI_OKAY});
            end
        end
    endtask

    task automatic rd(input logic [3:0] a);
        bit done;
        done = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                done = 1;
                rd_q = rdata;
                rready <= 1'b0;
                chk({30'h0, rresp}, {30'h0, AXI_OKAY});
            end
        end
    endtask

    // routes are registered: one edge to update, one more to be safe
    task automatic settle();
        repeat (2) @(posedge clk);
    endtask

    function automatic logic [23:0] mc_exp(input logic [2:0] c, input logic lg);
        logic [11:0] n;
        case (c[2:1])
            2'd2: n = lg ? 12'h678 : 12'h67f;
            2'd3: n = lg ? 12'h9ff : 12'hfff;
            default: n = 12'heee;
        endcase
        return {(c[0] ? (lg ? 12'h345 : 12'h3ff) : 12'h012), n};
    endfunction

    // small variant lacks inputs 4, 5, 8 and 9
    function automatic logic [3:0] c0_exp(input logic [4:0] c, input logic lg);
        if (c <= 5'd3 || c == 5'd6 || c == 5'd7 || (lg && c <= 5'd9)) begin
            return c[3:0];
        end
        return RT_NONE;
    endfunction

    task automatic mc_chk(input logic b, input logic [2:0] c);
        sel_b <= b;
        settle();
        chk({8'h0, r1p, r2p, r3p, r1n, r2n, r3n}, {8'h0, mc_exp(c, 1'b1)});
        chk({8'h0, s_r1p, s_r2p, s_r3p, s_r1n, s_r2n, s_r3n}, {8'h0, mc_exp(c, 1'b0)});
    endtask

    task automatic c0_chk(input logic b, input logic [4:0] c, input logic ng);
        sel_b <= b;
        settle();
        chk({24'h0, r0p, r0n}, {24'h0, c0_exp(c, 1'b1), ng ? 4'h1 : RT_VREF});
        chk({24'h0, s_r0p, s_r0n}, {24'h0, c0_exp(c, 1'b0), ng ? 4'h1 : RT_VREF});
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            summarize();
        end
    end

    // ********************************
    // main sequence
    // ********************************
    initial begin
        logic [3:0]  offs [4];
        logic [15:0] msk  [4];
        offs = '{MULTI_SEL_OFF, FIRST_SEL_OFF, SCAN_MASK_OFF, PIN_CFG_OFF};
        msk  = '{MULTI_SEL_MASK, FIRST_SEL_MASK, TEN_BIT_MASK, TEN_BIT_MASK};
        n_errors = 0; checks_done = 0; cycles = 0;
        rst_b = 1'b0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
        awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0; tw = 0; sel_b = 0; dis = 0;
        scan_act = 0; scan_in = 4'h0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            rd(offs[i]);
            chk(rd_q, 32'h0);
        end
        mc_chk(1'b0, 3'd0);
        c0_chk(1'b0, 5'd0, 1'b0);
        chk({2'h0, scan_inc, pin_dig, prd_en}, 32'h0);
        // all-ones write: reserved bits must read back zero
        for (int i = 0; i < 4; i++) begin
            wr(offs[i], 32'hffffffff);
            rd(offs[i]);
            chk(rd_q, {16'h0, msk[i]});
        end
        for (int c = 0; c < 8; c++) begin
            wr(MULTI_SEL_OFF, {21'h0, 3'(7 - c), 5'h0, 3'(c)});
            mc_chk(1'b0, 3'(c));
            mc_chk(1'b1, 3'(7 - c));
        end
        tw <= 1'b1;
        settle();
        chk({8'h0, r1p, r2p, r3p, r1n, r2n, r3n}, 32'h00ffffff);
        chk({8'h0, s_r1p, s_r2p, s_r3p, s_r1n, s_r2n, s_r3n}, 32'h00ffffff);
        tw <= 1'b0;
        for (int c = 0; c < 11; c++) begin
            wr(FIRST_SEL_OFF, {16'h0, ~1'(c), 2'b0, 5'(10 - c), 1'(c), 2'b0, 5'(c)});
            c0_chk(1'b0, 5'(c), 1'(c));
            c0_chk(1'b1, 5'(10 - c), ~1'(c));
        end
        wr(FIRST_SEL_OFF, 32'h0);
        sel_b <= 1'b0;
        scan_act <= 1'b1;
        scan_in <= 4'h5;
        settle();
        chk({28'h0, r0p}, 32'h5);
        chk({28'h0, s_r0p}, {28'h0, RT_VREF});
        scan_in <= 4'hc;
        settle();
        chk({28'h0, r0p}, {28'h0, RT_VREF});
        scan_act <= 1'b0;
        wr(SCAN_MASK_OFF, 32'h2a5);
        settle();
        chk({22'h0, scan_inc}, 32'h2a5);
        wr(PIN_CFG_OFF, 32'h155);
        settle();
        chk({2'h0, pin_dig, prd_en, mux_gnd}, {2'h0, 10'h155, 10'h155, 10'h155});
        chk({22'h0, s_pin_dig}, 32'h045);
        dis <= 1'b1;
        settle();
        chk({2'h0, pin_dig, prd_en, mux_gnd}, {2'h0, 10'h3ff, 10'h3ff, 10'h3ff});
        chk({22'h0, s_pin_dig}, 32'h0cf);
        dis <= 1'b0;
        settle();
        chk({22'h0, pin_dig}, 32'h155);
        // mid-run reset must clear every register again
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            rd(offs[i]);
            chk(rd_q, 32'h0);
        end
        mc_chk(1'b0, 3'd0);
        c0_chk(1'b0, 5'd0, 1'b0);
        summarize();
    end
endmodule
